/* File: src/cpcfg_defs.vh */
// Register map, field positions, reset values and timing counts of the port configuration bank
`ifndef CPCFG_DEFS_VH
`define CPCFG_DEFS_VH

`define CPCFG_ADDR_GENERAL      8'h15
`define CPCFG_ADDR_EMULATION    8'h16

`define CPCFG_GEN_RESET         8'h01
`define CPCFG_EMU_RESET         8'h8C
`define CPCFG_GEN_WMASK         8'hBF
`define CPCFG_EMU_WMASK         8'h9F

`define CPCFG_GEN_NOTIFY_MASK   7
`define CPCFG_GEN_NOTIFY_LINK   5
`define CPCFG_GEN_DISCHARGE     4
`define CPCFG_GEN_BUDGET_EN     3
`define CPCFG_GEN_BUDGET_CLR    2
`define CPCFG_GEN_ACTION_HI     1
`define CPCFG_GEN_ACTION_LO     0

`define CPCFG_EMU_BUS_TO_DIS    7
`define CPCFG_EMU_EMU_TO_DIS    4
`define CPCFG_EMU_RESTART       3
`define CPCFG_EMU_HOLD          2
`define CPCFG_EMU_RST_HI        1
`define CPCFG_EMU_RST_LO        0

`define CPCFG_ACT_REPORT        2'h0
`define CPCFG_ACT_REPORT_DISC   2'h1
`define CPCFG_ACT_DISC_SLEEP    2'h2
`define CPCFG_ACT_IGNORE        2'h3

`define CPCFG_CLK_MHZ           125
`define CPCFG_RST_50_MS         50
`define CPCFG_RST_75_MS         75
`define CPCFG_RST_125_MS        125
`define CPCFG_RST_175_MS        175
`define CPCFG_MS_CYCLES(ms)     ((ms) * 1000 * `CPCFG_CLK_MHZ)
`define CPCFG_PROFILE_TO_MS     1000

`endif

/* File: src/cpcfg_sync.v */
// Two-flip-flop synchroniser for pin-level inputs
module cpcfg_sync #(
   parameter W = 1
) (
   input  wire         clk_i,
   input  wire         rst_n_i,
   input  wire [W-1:0] d_i,
   output reg  [W-1:0] q_o
);
   reg [W-1:0] meta_q;
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= {W{1'b0}};
         q_o    <= {W{1'b0}};
      end else begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end
endmodule // cpcfg_sync

/* File: src/cpcfg_timer.v */
// Loadable down-counter with one-cycle expiry pulse
module cpcfg_timer (
   input  wire        clk_i,
   input  wire        rst_n_i,
   input  wire        load_i,
   input  wire [31:0] count_i,
   input  wire        stop_i,
   output reg         busy_o,
   output reg         done_o
);
   reg [31:0] cnt_q;
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q  <= 32'h0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (stop_i) begin
            busy_o <= 1'b0;
            cnt_q  <= 32'h0;
         end else if (load_i) begin
            busy_o <= 1'b1;
            cnt_q  <= count_i;
         end else if (busy_o) begin
            if (cnt_q <= 32'h1) begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
               cnt_q  <= 32'h0;
            end else begin
               cnt_q <= cnt_q - 32'h1;
            end
         end
      end
   end
endmodule // cpcfg_timer

/* File: src/cpcfg_top.v */
// Configuration bank of a USB port power controller with charge budget and charger emulation
`include "cpcfg_defs.vh"
module cpcfg_top #(
   parameter [31:0] PROFILE_TO_CYC = `CPCFG_MS_CYCLES(`CPCFG_PROFILE_TO_MS),
   parameter [31:0] RST_50_CYC     = `CPCFG_MS_CYCLES(`CPCFG_RST_50_MS),
   parameter [31:0] RST_75_CYC     = `CPCFG_MS_CYCLES(`CPCFG_RST_75_MS),
   parameter [31:0] RST_125_CYC    = `CPCFG_MS_CYCLES(`CPCFG_RST_125_MS),
   parameter [31:0] RST_175_CYC    = `CPCFG_MS_CYCLES(`CPCFG_RST_175_MS),
   parameter [31:0] DISCHARGE_CYC  = 32'd1000,
   parameter [3:0]  PROFILE_COUNT  = 4'h9
) (
   input  wire        MCLK_I,
   input  wire        RST_N_I,
   input  wire        WR_EN_I,
   input  wire        RD_EN_I,
   input  wire [7:0]  ADDR_I,
   input  wire [7:0]  WDATA_I,
   output reg  [7:0]  RDATA_O,
   input  wire        ACTIVE_I,
   input  wire        ERROR_I,
   input  wire        INDICATOR_EVT_I,
   input  wire        LOW_CURRENT_FLAG_I,
   input  wire        THERMAL_REGULATION_FLAG_I,
   input  wire        BUDGET_REACHED_I,
   input  wire        CHARGE_ABOVE_THRESHOLD_I,
   input  wire        REMOVAL_I,
   input  wire        EMULATE_DCC_I,
   output reg         FAULT_NOTIFY_N_O,
   output reg         SWITCH_CLOSE_O,
   output reg         DISCHARGE_O,
   output reg         BUDGET_ENABLE_O,
   output reg         ACCUM_CLEAR_O,
   output reg         BUDGET_FLAG_O,
   output reg         BUDGET_SLEEP_REQ_O,
   output reg         BUS_TIMEOUT_EN_O,
   output reg         PROFILE_APPLY_O,
   output reg  [3:0]  PROFILE_INDEX_O,
   output reg         PROFILE_ACCEPTED_O,
   output reg         EMU_RESET_O,
   output reg         DATA_LINES_HIZ_O
);
   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   wire [7:0] pins_s;
   cpcfg_sync #(.W(8)) u_sync (
      .clk_i   (MCLK_I),
      .rst_n_i (RST_N_I),
      .d_i     ({ACTIVE_I, ERROR_I, INDICATOR_EVT_I, LOW_CURRENT_FLAG_I,
                 THERMAL_REGULATION_FLAG_I, BUDGET_REACHED_I,
                 CHARGE_ABOVE_THRESHOLD_I, REMOVAL_I}),
      .q_o     (pins_s)
   );
   // Synchronised pin levels
   wire active_s = pins_s[7];
   wire error_s  = pins_s[6];
   wire ind_s    = pins_s[5];
   wire lowc_s   = pins_s[4];
   wire thermal_regulation_flag_s   = pins_s[3];
   wire reach_s  = pins_s[2];
   wire chg_s    = pins_s[1];
   wire remov_s  = pins_s[0];
   // Mode level from outside the clock domain, two flops
   reg  dcc_m_q;
   reg  dcc_q;
   always @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         dcc_m_q <= 1'b0;
         dcc_q   <= 1'b0;
      end else begin
         dcc_m_q <= EMULATE_DCC_I;
         dcc_q   <= dcc_m_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers, reset only by RST_N_I so contents survive Sleep
   // Unimplemented bits masked on write, so they read back as zero
   reg  [7:0] gen_q;
   reg  [7:0] emu_q;
   wire       wr_gen = WR_EN_I && (ADDR_I == `CPCFG_ADDR_GENERAL);
   wire       wr_emu = WR_EN_I && (ADDR_I == `CPCFG_ADDR_EMULATION);
   always @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         gen_q <= `CPCFG_GEN_RESET;
         emu_q <= `CPCFG_EMU_RESET;
      end else begin
         if (wr_gen)
            gen_q <= WDATA_I & `CPCFG_GEN_WMASK;
         if (wr_emu)
            emu_q <= WDATA_I & `CPCFG_EMU_WMASK;
      end
   end
   // Read data registered and held until the next read
   always @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) RDATA_O <= 8'h00;
      else if (RD_EN_I) begin
         case (ADDR_I)
            `CPCFG_ADDR_GENERAL:   RDATA_O <= gen_q;
            `CPCFG_ADDR_EMULATION: RDATA_O <= emu_q;
            default:               RDATA_O <= 8'h00;
         endcase
      end
   end
   // Field decode
   wire       n_mask   = gen_q[`CPCFG_GEN_NOTIFY_MASK];
   wire       n_link   = gen_q[`CPCFG_GEN_NOTIFY_LINK];
   wire       dis_f    = gen_q[`CPCFG_GEN_DISCHARGE];
   wire       b_en     = gen_q[`CPCFG_GEN_BUDGET_EN];
   wire       b_clr    = gen_q[`CPCFG_GEN_BUDGET_CLR];
   wire [1:0] b_act    = gen_q[`CPCFG_GEN_ACTION_HI:`CPCFG_GEN_ACTION_LO];
   wire       emu_tod  = emu_q[`CPCFG_EMU_EMU_TO_DIS];
   wire       restart  = emu_q[`CPCFG_EMU_RESTART];
   wire       hold     = emu_q[`CPCFG_EMU_HOLD];
   wire [1:0] rst_sel  = emu_q[`CPCFG_EMU_RST_HI:`CPCFG_EMU_RST_LO];

   ////////////////////////////////////////////////////////////////////////////////
   // Charge budget
   reg  reached_q;
   reg  budget_flag_q;
   wire budget_hit = b_en && reach_s && (b_act != `CPCFG_ACT_IGNORE);
   wire budget_drop = !b_en || b_clr;
   // Disable or clear wins over a threshold hit in the same cycle
   always @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         reached_q     <= 1'b0;
         budget_flag_q <= 1'b0;
      end else if (budget_drop) begin
         reached_q     <= 1'b0;
         budget_flag_q <= 1'b0;
      end else if (budget_hit) begin
         reached_q     <= 1'b1;
         budget_flag_q <= (b_act != `CPCFG_ACT_DISC_SLEEP);
      end
   end
   wire budget_disc = reached_q && (b_act == `CPCFG_ACT_REPORT_DISC ||
                                    b_act == `CPCFG_ACT_DISC_SLEEP);

   ////////////////////////////////////////////////////////////////////////////////
   // Emulation cycle
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_PROF = 3'h1;
   localparam [2:0] ST_HELD = 3'h2;
   localparam [2:0] ST_RST  = 3'h3;
   localparam [2:0] ST_DONE = 3'h4;
   reg  [2:0]  st_q;
   reg  [2:0]  st_d;
   reg  [3:0]  prof_q;
   reg  [3:0]  prof_d;
   reg         load;
   reg  [31:0] load_cnt;
   wire        tmr_busy;
   wire        tmr_done;
   reg  [31:0] rst_cyc;
   // Reset duration selected by field
   always @* begin
      case (rst_sel)
         2'h0:    rst_cyc = RST_50_CYC;
         2'h1:    rst_cyc = RST_75_CYC;
         2'h2:    rst_cyc = RST_125_CYC;
         default: rst_cyc = RST_175_CYC;
      endcase
   end
   // Expiry is acted on one edge late, so every load is one short
   wire [31:0] prof_load = PROFILE_TO_CYC - 32'h1;
   wire [31:0] rst_total = rst_cyc + DISCHARGE_CYC - 32'h1;
   wire        last_prof = (prof_q == PROFILE_COUNT - 4'h1);
   always @* begin
      st_d     = st_q;
      prof_d   = prof_q;
      load     = 1'b0;
      load_cnt = prof_load;
      case (st_q)
         ST_IDLE: begin
            if (dcc_q && active_s) begin
               st_d   = ST_PROF;
               prof_d = 4'h0;
               load   = 1'b1;
            end
         end
         ST_PROF: begin
            // Early acceptance only with timeout disabled or hold set
            if (chg_s && (emu_tod || hold)) begin
               st_d = ST_HELD;
            end else if (tmr_done && !emu_tod) begin
               if (chg_s) begin
                  st_d = ST_HELD;
               end else if (!last_prof) begin
                  prof_d = prof_q + 4'h1;
                  load   = 1'b1;
               end else if (restart) begin
                  st_d     = ST_RST;
                  load     = 1'b1;
                  load_cnt = rst_total;
               end else begin
                  st_d = ST_DONE;
               end
            end
         end
         ST_HELD: begin
            if (remov_s || thermal_regulation_flag_s) begin
               st_d     = ST_RST;
               load     = 1'b1;
               load_cnt = rst_total;
            end
         end
         ST_RST: begin
            if (tmr_done) begin
               st_d   = ST_PROF;
               prof_d = 4'h0;
               load   = 1'b1;
            end
         end
         ST_DONE: begin
            if (remov_s) st_d = ST_IDLE;
         end
         default: st_d = ST_IDLE;
      endcase
      // Leaving charger mode or Active drops the cycle to idle
      if (!dcc_q || !active_s) begin
         st_d = ST_IDLE;
         load = 1'b0;
      end
   end
   always @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         st_q   <= ST_IDLE;
         prof_q <= 4'h0;
      end else begin
         st_q   <= st_d;
         prof_q <= prof_d;
      end
   end
   // Timer stopped while idle, accepted or finished
   cpcfg_timer u_timer (
      .clk_i   (MCLK_I),
      .rst_n_i (RST_N_I),
      .load_i  (load),
      .count_i (load_cnt),
      .stop_i  (st_d == ST_IDLE || st_d == ST_HELD || st_d == ST_DONE),
      .busy_o  (tmr_busy),
      .done_o  (tmr_done)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   // Errors, indicators, budget flag and linked flags share one notify
   wire notify = !n_mask && (error_s || ind_s || budget_flag_q ||
                             (n_link && (lowc_s || thermal_regulation_flag_s)));
   always @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         FAULT_NOTIFY_N_O   <= 1'b1;
         SWITCH_CLOSE_O     <= 1'b0;
         DISCHARGE_O        <= 1'b0;
         BUDGET_ENABLE_O    <= 1'b0;
         ACCUM_CLEAR_O      <= 1'b1;
         BUDGET_FLAG_O      <= 1'b0;
         BUDGET_SLEEP_REQ_O <= 1'b0;
         BUS_TIMEOUT_EN_O   <= 1'b0;
         PROFILE_APPLY_O    <= 1'b0;
         PROFILE_INDEX_O    <= 4'h0;
         PROFILE_ACCEPTED_O <= 1'b0;
         EMU_RESET_O        <= 1'b0;
         DATA_LINES_HIZ_O   <= 1'b1;
      end else begin
         FAULT_NOTIFY_N_O   <= !notify;
         // Switch closed only while Active, opened by discharge force, budget disconnect or emulation reset
         SWITCH_CLOSE_O     <= active_s && !(dis_f) && !budget_disc &&
                               st_q != ST_RST;
         DISCHARGE_O        <= (active_s && dis_f) || st_q == ST_RST;
         BUDGET_ENABLE_O    <= b_en;
         ACCUM_CLEAR_O      <= budget_drop;
         BUDGET_FLAG_O      <= budget_flag_q;
         BUDGET_SLEEP_REQ_O <= reached_q && b_act == `CPCFG_ACT_DISC_SLEEP;
         BUS_TIMEOUT_EN_O   <= !emu_q[`CPCFG_EMU_BUS_TO_DIS];
         PROFILE_APPLY_O    <= (st_q == ST_PROF) || (st_q == ST_HELD && hold);
         PROFILE_INDEX_O    <= prof_q;
         PROFILE_ACCEPTED_O <= st_q == ST_HELD;
         EMU_RESET_O        <= st_q == ST_RST;
         DATA_LINES_HIZ_O   <= !(st_q == ST_PROF || (st_q == ST_HELD && hold));
      end
   end
endmodule // cpcfg_top

/* File: tb/cpcfg_host.sv */
// Host model on the register strobe bus
module cpcfg_host (
   input  wire       clk_i,
   input  wire [7:0] rdata_i,
   output reg        wr_en_o,
   output reg        rd_en_o,
   output reg  [7:0] addr_o,
   output reg  [7:0] wdata_o,
   output reg        rvld_o,
   output reg  [7:0] rdat_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {wr_en_o, rd_en_o, rvld_o, addr_o, wdata_o, rdat_o} = 0;
   end
   task wr(input [7:0] a, input [7:0] d);
      @(negedge clk_i);
      addr_o = a;
      wdata_o = d;
      wr_en_o = 1'b1;
      @(negedge clk_i);
      wr_en_o = 1'b0;
   endtask
   // Read data taken one edge after the strobe
   task rd(input [7:0] a);
      @(negedge clk_i);
      addr_o = a;
      rd_en_o = 1'b1;
      @(negedge clk_i);
      rd_en_o = 1'b0;
      rdat_o = rdata_i;
      rvld_o = 1'b1;
      @(negedge clk_i);
      rvld_o = 1'b0;
   endtask
endmodule // cpcfg_host

/* File: tb/cpcfg_props.sv */
// Port checker of the configuration bank
module cpcfg_props (
   input wire       MCLK_I,
   input wire       RST_N_I,
   input wire       WR_EN_I,
   input wire       RD_EN_I,
   input wire [7:0] ADDR_I,
   input wire [7:0] WDATA_I,
   input wire [7:0] RDATA_O,
   input wire       ACTIVE_I,
   input wire       ERROR_I,
   input wire       FAULT_NOTIFY_N_O,
   input wire       SWITCH_CLOSE_O,
   input wire       DISCHARGE_O,
   input wire       BUDGET_ENABLE_O,
   input wire       ACCUM_CLEAR_O,
   input wire       BUDGET_FLAG_O,
   input wire       BUDGET_SLEEP_REQ_O,
   input wire       BUS_TIMEOUT_EN_O,
   input wire       PROFILE_ACCEPTED_O
);
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (!RST_N_I);
   reg [7:0] gen_q;
   reg [7:0] emu_q;
   // Shadow of both registers
   always @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         gen_q <= 8'h01;
         emu_q <= 8'h8C;
      end else if (WR_EN_I) begin
         if (ADDR_I == 8'h15) gen_q <= WDATA_I & 8'hBF;
         if (ADDR_I == 8'h16) emu_q <= WDATA_I & 8'h9F;
      end
   end
   AST_RD_GEN: assert property (RD_EN_I && ADDR_I == 8'h15 |=> RDATA_O == $past(gen_q))
      else $error("general read wrong");
   AST_RD_EMU: assert property (RD_EN_I && ADDR_I == 8'h16 |=> RDATA_O == $past(emu_q))
      else $error("emulation read wrong");
   AST_UNMAP: assert property (RD_EN_I && ADDR_I != 8'h15 && ADDR_I != 8'h16 |=> RDATA_O == 8'h00)
      else $error("unmapped read not zero");
   AST_MASK: assert property ($past(gen_q[7]) |-> FAULT_NOTIFY_N_O)
      else $error("notify driven while masked");
   AST_NOTIFY: assert property (ERROR_I [*4] ##0 !$past(gen_q[7]) |-> !FAULT_NOTIFY_N_O)
      else $error("error not notified");
   AST_BUS_TO: assert property (BUS_TIMEOUT_EN_O == !$past(emu_q[7]))
      else $error("bus timeout enable wrong");
   AST_BUDGET_EN: assert property (BUDGET_ENABLE_O == $past(gen_q[3]))
      else $error("budget enable wrong");
   AST_CLEAR: assert property (!$past(gen_q[3]) || $past(gen_q[2]) |-> ACCUM_CLEAR_O)
      else $error("charge not cleared");
   AST_FLAG_CLR: assert property (!$past(gen_q[3], 2) || $past(gen_q[2], 2) |-> !BUDGET_FLAG_O)
      else $error("budget flag not cleared");
   AST_DISCHARGE: assert property (ACTIVE_I [*4] ##0 $past(gen_q[4]) |-> DISCHARGE_O && !SWITCH_CLOSE_O)
      else $error("discharge not forced");
   AST_SLEEP: assert property ($rose(BUDGET_SLEEP_REQ_O) |-> $past(gen_q[1:0]) == 2'h2)
      else $error("sleep request with wrong action");
   cover property (PROFILE_ACCEPTED_O);
   cover property (!FAULT_NOTIFY_N_O);
   cover property ($rose(DISCHARGE_O));
endmodule // cpcfg_props

bind cpcfg_top cpcfg_props u_props (.*);

/* File: tb/tb_charge_port_config_regs.sv */
// Self-checking bench of the port configuration bank
module tb_charge_port_config_regs;
   timeunit 1ns;
   timeprecision 1ps;
   localparam PTO = 20;
   localparam DSC = 4;
   reg        clk, rst_n, act, err, ind, lowc, therm, reach, chg, remv, dcc;
   wire       wr_en, rd_en, rvld, ntf_n, sw_cl, dsch, b_en, acc_clr, b_flag, slp;
   wire       bto_en, apply, accd, emu_rst, hiz;
   wire [7:0] addr, wdata, rdata, rdat;
   wire [3:0] pidx;
   reg  [3:0] pl;
   reg  [7:0] d;
   reg  [7:0] expq [$];
   integer    mismatches, n_checks, seed, i, n;
   cpcfg_top #(.PROFILE_TO_CYC(PTO), .RST_50_CYC(5), .RST_75_CYC(6), .RST_125_CYC(8),
      .RST_175_CYC(10), .DISCHARGE_CYC(DSC)) DUT (
      .MCLK_I(clk), .RST_N_I(rst_n), .WR_EN_I(wr_en), .RD_EN_I(rd_en), .ADDR_I(addr),
      .WDATA_I(wdata), .RDATA_O(rdata), .ACTIVE_I(act), .ERROR_I(err),
      .INDICATOR_EVT_I(ind), .LOW_CURRENT_FLAG_I(lowc), .THERMAL_REGULATION_FLAG_I(therm),
      .BUDGET_REACHED_I(reach), .CHARGE_ABOVE_THRESHOLD_I(chg), .REMOVAL_I(remv),
      .EMULATE_DCC_I(dcc), .FAULT_NOTIFY_N_O(ntf_n), .SWITCH_CLOSE_O(sw_cl),
      .DISCHARGE_O(dsch), .BUDGET_ENABLE_O(b_en), .ACCUM_CLEAR_O(acc_clr),
      .BUDGET_FLAG_O(b_flag), .BUDGET_SLEEP_REQ_O(slp), .BUS_TIMEOUT_EN_O(bto_en),
      .PROFILE_APPLY_O(apply), .PROFILE_INDEX_O(pidx), .PROFILE_ACCEPTED_O(accd),
      .EMU_RESET_O(emu_rst), .DATA_LINES_HIZ_O(hiz));
   cpcfg_host host (.clk_i(clk), .rdata_i(rdata), .wr_en_o(wr_en), .rd_en_o(rd_en),
      .addr_o(addr), .wdata_o(wdata), .rvld_o(rvld), .rdat_o(rdat));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task cmp(input [7:0] got, input [7:0] exp);
      n_checks = n_checks + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("MISMATCH %0t read %h exp %h", $time, got, exp);
      end
   endtask
   task pin(input got, input exp);
      n_checks = n_checks + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("MISMATCH %0t pin %b exp %b", $time, got, exp);
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task rdx(input [7:0] a, input [7:0] e);
      expq.push_back(e);
      host.rd(a);
   endtask
   // Read results matched against the oldest note
   always @(posedge clk) begin
      if (rvld === 1'b1) cmp(rdat, expq.pop_front());
   end
   function logic probe(input integer s);
      case (s)
         0: probe = emu_rst;
         1: probe = !emu_rst;
         2: probe = accd;
         default: probe = pidx != pl;
      endcase
   endfunction
   task waitp(input integer s, input integer lim, output integer c);
      c = 0;
      while (probe(s) !== 1'b1 && c < lim) begin
         @(negedge clk);
         c = c + 1;
      end
      if (c >= lim) begin
         mismatches = mismatches + 1;
         $display("MISMATCH %0t wait ran out", $time);
         conclude;
      end
   endtask
   initial begin
      {act, err, ind, lowc, therm, reach, chg, remv, dcc} = 0;
      mismatches = 0;
      n_checks = 0;
      seed = 32'h5667;
      rst_n = 1'b0;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      rdx(8'h15, 8'h01);
      rdx(8'h16, 8'h8C);
      rdx(8'h17, 8'h00);
      pin(bto_en, 1'b0);
      for (i = 0; i < 6; i = i + 1) begin
         n = $random(seed);
         d = (i == 0) ? 8'hFF : n[7:0];
         host.wr(8'h15, d);
         host.wr(8'h16, d);
         rdx(8'h15, d & 8'hBF);
         rdx(8'h16, d & 8'h9F);
      end
      host.wr(8'h16, 8'h00);
      repeat (3) @(negedge clk);
      pin(bto_en, 1'b1);
      $display("registers done");
      host.wr(8'h15, 8'h80);
      err = 1'b1;
      repeat (5) @(negedge clk);
      pin(ntf_n, 1'b1);
      host.wr(8'h15, 8'h00);
      repeat (4) @(negedge clk);
      pin(ntf_n, 1'b0);
      err = 1'b0;
      therm = 1'b1;
      repeat (5) @(negedge clk);
      pin(ntf_n, 1'b1);
      host.wr(8'h15, 8'h20);
      repeat (4) @(negedge clk);
      pin(ntf_n, 1'b0);
      therm = 1'b0;
      act = 1'b1;
      host.wr(8'h15, 8'h10);
      repeat (PTO) @(negedge clk);
      pin(dsch, 1'b1);
      pin(sw_cl, 1'b0);
      rdx(8'h15, 8'h10);
      $display("notify and discharge done");
      for (i = 0; i < 4; i = i + 1) begin
         host.wr(8'h15, 8'h0C);
         host.wr(8'h15, 8'h08 | i[1:0]);
         reach = 1'b1;
         repeat (5) @(negedge clk);
         pin(b_en, 1'b1);
         pin(slp, i == 2);
         if (i < 2) pin(b_flag, 1'b1);
         else pin(b_flag, 1'b0);
         pin(sw_cl, i == 0 || i == 3);
         host.wr(8'h15, 8'h0E);
         repeat (3) @(negedge clk);
         pin(b_flag, 1'b0);
         pin(acc_clr, 1'b1);
         host.wr(8'h15, 8'h0A);
         repeat (4) @(negedge clk);
         host.wr(8'h15, 8'h02);
         repeat (3) @(negedge clk);
         pin(slp | b_flag | !acc_clr, 1'b0);
         reach = 1'b0;
      end
      $display("budget done");
      dcc = 1'b1;
      for (i = 0; i < 8; i = i + 1) begin
         pl = pidx;
         waitp(3, 3 * PTO, n);
         if (i > 0) pin(n >= PTO && n <= PTO + 2, 1'b1);
      end
      repeat (PTO + 8) @(negedge clk);
      pin(hiz && sw_cl && pidx == 4'h8 && !emu_rst, 1'b1);
      for (i = 0; i < 4; i = i + 1) begin
         dcc = 1'b0;
         host.wr(8'h16, 8'h08 | i[1:0]);
         dcc = 1'b1;
         waitp(0, 12 * PTO, n);
         waitp(1, 40, n);
         pin(n == (i == 0 ? 5 : i == 1 ? 6 : i == 2 ? 8 : 10) + DSC, 1'b1);
         repeat (2) @(negedge clk);
         pin(pidx == 4'h0 && apply, 1'b1);
      end
      dcc = 1'b0;
      host.wr(8'h16, 8'h10);
      dcc = 1'b1;
      repeat (3 * PTO) @(negedge clk);
      pin(pidx == 4'h0 && apply, 1'b1);
      chg = 1'b1;
      waitp(2, 6, n);
      chg = 1'b0;
      dcc = 1'b0;
      host.wr(8'h16, 8'h04);
      dcc = 1'b1;
      repeat (PTO / 2) @(negedge clk);
      chg = 1'b1;
      waitp(2, 6, n);
      repeat (3 * PTO) @(negedge clk);
      pin(apply && accd, 1'b1);
      chg = 1'b0;
      remv = 1'b1;
      repeat (6) @(negedge clk);
      pin(accd, 1'b0);
      remv = 1'b0;
      dcc = 1'b0;
      host.wr(8'h16, 8'h00);
      dcc = 1'b1;
      chg = 1'b1;
      waitp(2, 3 * PTO, n);
      pin(n >= PTO, 1'b1);
      pin(apply, 1'b0);
      chg = 1'b0;
      $display("emulation done");
      host.wr(8'h16, 8'h80);
      conclude;
   end
endmodule // tb_charge_port_config_regs
